/* File: core/timing_polarity_map.svh */
// Register indexes, byte addresses, field positions and reset values of the timing config block.
`ifndef TIMING_POLARITY_MAP_SVH
`define TIMING_POLARITY_MAP_SVH

`define APB_ADDR_WIDTH          12
`define REG_WIDTH               16

`define IDX_STD_SOURCE_CTRL     8'h4C
`define IDX_HOST_VIDEO_STD      8'h4D
`define IDX_TIMING_POLARITY     8'h56
`define IDX_STANDARD_STATUS     8'h60

`define ADDR_STD_SOURCE_CTRL    ({2'h0, `IDX_STD_SOURCE_CTRL, 2'b00})
`define ADDR_HOST_VIDEO_STD     ({2'h0, `IDX_HOST_VIDEO_STD, 2'b00})
`define ADDR_TIMING_POLARITY    ({2'h0, `IDX_TIMING_POLARITY, 2'b00})
`define ADDR_STANDARD_STATUS    ({2'h0, `IDX_STANDARD_STATUS, 2'b00})

`define BIT_HOST_STD_SELECT     1
`define MSB_HOST_STD            5
`define BIT_POL_AFS             9
`define BIT_POL_TEN_FIELD       8
`define BIT_POL_DE              7
`define BIT_POL_FIELD           5
`define LSB_STATUS_PINS         8
`define BIT_STATUS_HOST_ACTIVE  15

`define MASK_STD_SOURCE_CTRL    16'h0002
`define MASK_HOST_VIDEO_STD     16'h003F
`define MASK_TIMING_POLARITY    16'h03A0

`define RST_STD_SOURCE_CTRL     16'h0000
`define RST_HOST_VIDEO_STD      16'h0000
`define RST_TIMING_POLARITY     16'h0000

`endif

/* File: core/timing_polarity_pkg.sv */
// Types shared by the timing polarity and standard select block.
package timing_polarity_pkg;

    typedef logic [5:0] video_std_type;

    typedef enum logic [1:0] {
        TOUT_AFS       = 2'b00,
        TOUT_TEN_FIELD = 2'b01,
        TOUT_DE        = 2'b10,
        TOUT_FIELD     = 2'b11
    } timing_out_type;

    typedef enum logic [2:0] {
        SEL_NONE      = 3'b000,
        SEL_CTRL      = 3'b001,
        SEL_HOST_STD  = 3'b010,
        SEL_POLARITY  = 3'b011,
        SEL_STATUS    = 3'b100
    } reg_sel_type;

endpackage

/* File: core/timing_pol_if.sv */
// Carrier between the timing shaper and the polarity output stage.
`timescale 1ns/100ps
`default_nettype none
interface timing_pol_if #(
    parameter int N = 4
);
    logic [N-1:0] raw;
    logic [N-1:0] invert;
    logic [N-1:0] present;
    logic [N-1:0] out;

    modport core (output raw, output invert, output present, input out);
    modport stage (input raw, input invert, input present, output out);
endinterface
`default_nettype wire

/* File: core/pin_sync.sv */
// Two-flop synchroniser for a vector of asynchronous pin levels.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             pclk,     // System clock.
    input  wire logic             presetn,  // Asynchronous reset, active low.
    input  wire logic [WIDTH-1:0] pin_in,   // Asynchronous pin levels.
    output logic      [WIDTH-1:0] pin_out   // Synchronised levels.
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pin_out = sync_q;
endmodule
`default_nettype wire

/* File: core/polarity_stage.sv */
// Registered polarity inversion of the timing outputs.
`timescale 1ns/100ps
`default_nettype none
module polarity_stage #(
    parameter int N = 4
) (
    input  wire logic   pclk,     // System clock.
    input  wire logic   presetn,  // Asynchronous reset, active low.
    timing_pol_if.stage pol       // Raw timing, inversion and presence bits.
);
    logic [N-1:0] out_q;
    logic [N-1:0] out_d;

    generate
        for (genvar i = 0; i < N; i++) begin : g_bit
            // An output whose source is absent stays low whatever its polarity bit.
            always_comb begin
                out_d[i] = pol.present[i] & (pol.raw[i] ^ pol.invert[i]);
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_q <= '0;
        end else begin
            out_q <= out_d;
        end
    end

    assign pol.out = out_q;
endmodule
`default_nettype wire

/* File: core/timing_polarity_std_select.sv */
// Video standard source select and timing output polarity registers behind APB.
//
// The implementer's own choice: register access over APB.
`include "timing_polarity_map.svh"
`timescale 1ns/100ps
`default_nettype none
module timing_polarity_std_select #(
    parameter bit AUDIO_PRESENT = 1'b1  // Variant with audio clock generation.
) (
    input  wire logic                       pclk,                // APB clock, 25 MHz.
    input  wire logic                       presetn,             // Reset, active low.
    // The APB slave side follows.
    input  wire logic                       psel,                // APB select.
    input  wire logic                       penable,             // APB access phase.
    input  wire logic                       pwrite,              // APB write.
    input  wire logic [`APB_ADDR_WIDTH-1:0] paddr,               // APB byte address.
    input  wire logic [31:0]                pwdata,              // APB write data.
    input  wire logic [3:0]                 pstrb,               // APB byte strobes.
    output logic      [31:0]                prdata,              // APB read data.
    output logic                            pready,              // APB ready.
    output logic                            pslverr,             // APB error.
    // Strap pins and timing events follow.
    input  wire logic [5:0]                 video_standard_pins, // Standard strap pins.
    input  wire logic                       line_start,          // Pulse at each line start.
    input  wire logic                       aclk_div_reset,      // Pulse: dividers reset, line 1.
    input  wire logic                       ten_field_start,     // Pulse: ten-field sequence start.
    input  wire logic                       active_pixel,        // Active picture level.
    input  wire logic                       field_one,           // Field 1 level.
    // The effective standard and the shaped outputs follow.
    output logic      [5:0]                 video_standard,      // Effective output standard.
    output logic                            audio_frame_sync,    // Audio frame sync output.
    output logic                            ten_field_identifier, // Ten-field identifier output.
    output logic                            display_enable,      // Display enable output.
    output logic                            digital_field        // Digital field flag output.
);
    // Four outputs share one polarity stage.
    localparam int NOUT = 4;

    // Any address outside the map decodes as unmapped.
    function automatic timing_polarity_pkg::reg_sel_type decode(
        input logic [`APB_ADDR_WIDTH-1:0] addr
    );
        timing_polarity_pkg::reg_sel_type sel;
        sel = timing_polarity_pkg::SEL_NONE;

        case (addr)
            `ADDR_STD_SOURCE_CTRL: sel = timing_polarity_pkg::SEL_CTRL;
            `ADDR_HOST_VIDEO_STD:  sel = timing_polarity_pkg::SEL_HOST_STD;
            `ADDR_TIMING_POLARITY: sel = timing_polarity_pkg::SEL_POLARITY;
            `ADDR_STANDARD_STATUS: sel = timing_polarity_pkg::SEL_STATUS;
            default:               sel = timing_polarity_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction

    // The mask keeps reserved bits at zero.
    function automatic logic [`REG_WIDTH-1:0] merge(
        input logic [`REG_WIDTH-1:0] old_val,
        input logic [31:0]           wdata,
        input logic [3:0]            strb,
        input logic [`REG_WIDTH-1:0] mask
    );
        logic [`REG_WIDTH-1:0] val;
        val = old_val;

        if (strb[0]) begin
            val[7:0] = wdata[7:0];
        end
        if (strb[1]) begin
            val[15:8] = wdata[15:8];
        end

        return val & mask;
    endfunction

    // These decode the held bus address.
    timing_polarity_pkg::reg_sel_type setup_sel;
    timing_polarity_pkg::reg_sel_type access_sel;
    logic                             setup_phase;
    logic                             write_access;

    // These hold the registers and the bus answer.
    logic [`REG_WIDTH-1:0] ctrl_q;
    logic [`REG_WIDTH-1:0] ctrl_d;
    logic [`REG_WIDTH-1:0] host_std_q;
    logic [`REG_WIDTH-1:0] host_std_d;
    logic [`REG_WIDTH-1:0] polarity_q;
    logic [`REG_WIDTH-1:0] polarity_d;
    logic [31:0]           rdata_q;
    logic [31:0]           rdata_d;
    logic                  err_q;
    logic                  err_d;

    // These carry the standard path.
    logic [5:0]            pins_sync;
    logic [5:0]            std_q;
    logic [5:0]            std_d;
    logic [`REG_WIDTH-1:0] status_val;

    // These hold the shaped timing levels.
    logic                  afs_q;
    logic                  afs_d;
    logic                  tfid_q;
    logic                  tfid_d;
    logic                  de_q;
    logic                  de_d;
    logic                  field_q;
    logic                  field_d;

    // The address holds through both phases.
    assign setup_sel    = decode(paddr);
    assign access_sel   = decode(paddr);
    assign setup_phase  = psel & ~penable;
    assign write_access = psel & penable & pwrite;

    // Register writes land on the access edge; reserved bits are never stored.
    always_comb begin
        ctrl_d     = ctrl_q;
        host_std_d = host_std_q;
        polarity_d = polarity_q;

        if (write_access) begin
            case (access_sel)
                timing_polarity_pkg::SEL_CTRL: begin
                    ctrl_d = merge(ctrl_q, pwdata, pstrb, `MASK_STD_SOURCE_CTRL);
                end
                timing_polarity_pkg::SEL_HOST_STD: begin
                    host_std_d = merge(host_std_q, pwdata, pstrb, `MASK_HOST_VIDEO_STD);
                end
                timing_polarity_pkg::SEL_POLARITY: begin
                    polarity_d = merge(polarity_q, pwdata, pstrb, `MASK_TIMING_POLARITY);
                end
                // Status and unmapped writes change nothing.
                default: begin
                    ctrl_d = ctrl_q;
                end
            endcase
        end
    end

    // Status shows what builds the output standard.
    always_comb begin
        status_val = '0;
        status_val[`MSB_HOST_STD:0] = std_q;
        status_val[`LSB_STATUS_PINS +: 6] = pins_sync;
        status_val[`BIT_STATUS_HOST_ACTIVE] = ctrl_q[`BIT_HOST_STD_SELECT];
    end

    // Read data and error are captured in the setup cycle; prdata leaves a flip-flop, pslverr is err_q gated by psel and penable.
    always_comb begin
        rdata_d = rdata_q;
        err_d   = err_q;

        if (setup_phase) begin
            err_d   = (setup_sel == timing_polarity_pkg::SEL_NONE);
            rdata_d = '0;
            // A write leaves zero as read data.
            if (!pwrite) begin
                case (setup_sel)
                    timing_polarity_pkg::SEL_CTRL:     rdata_d = {16'h0000, ctrl_q};
                    timing_polarity_pkg::SEL_HOST_STD: rdata_d = {16'h0000, host_std_q};
                    timing_polarity_pkg::SEL_POLARITY: rdata_d = {16'h0000, polarity_q};
                    timing_polarity_pkg::SEL_STATUS:   rdata_d = {16'h0000, status_val};
                    default:                           rdata_d = '0;
                endcase
            end
        end
    end

    // Reset gives default polarity and pin selection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= `RST_STD_SOURCE_CTRL;
            host_std_q <= `RST_HOST_VIDEO_STD;
            polarity_q <= `RST_TIMING_POLARITY;
            rdata_q    <= '0;
            err_q      <= 1'b0;
        end else begin
            ctrl_q     <= ctrl_d;
            host_std_q <= host_std_d;
            polarity_q <= polarity_d;
            rdata_q    <= rdata_d;
            err_q      <= err_d;
        end
    end

    // Zero wait states; each access ends at once.
    assign prdata  = rdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & err_q;

    // Strap pins are asynchronous to pclk.
    pin_sync #(
        .WIDTH (6)
    ) u_std_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  (video_standard_pins),
        .pin_out (pins_sync)
    );

    // The pins never reach the output while the host code is selected.
    always_comb begin
        if (ctrl_q[`BIT_HOST_STD_SELECT]) begin
            std_d = host_std_q[`MSB_HOST_STD:0];
        end else begin
            std_d = pins_sync;
        end
    end

    // Default-sense shaping of the timing outputs, one line held where needed.
    always_comb begin
        afs_d = afs_q;
        // A pulse and a line start together keep it set.
        if (aclk_div_reset) begin
            afs_d = 1'b1;
        end else if (line_start) begin
            afs_d = 1'b0;
        end

        tfid_d = tfid_q;
        if (ten_field_start) begin
            tfid_d = 1'b1;
        end else if (line_start) begin
            tfid_d = 1'b0;
        end

        de_d    = active_pixel;
        field_d = field_one;
    end

    // Shaping adds one cycle and the stage a second.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            std_q   <= '0;
            afs_q   <= 1'b0;
            tfid_q  <= 1'b0;
            de_q    <= 1'b0;
            field_q <= 1'b0;
        end else begin
            std_q   <= std_d;
            afs_q   <= afs_d;
            tfid_q  <= tfid_d;
            de_q    <= de_d;
            field_q <= field_d;
        end
    end

    // The standard leaves a flip-flop.
    assign video_standard = std_q;

    // Levels and control bits travel as one bundle.
    timing_pol_if #(.N(NOUT)) pol ();

    always_comb begin
        pol.raw     = '0;
        pol.invert  = '0;
        pol.present = '1;

        pol.raw[timing_polarity_pkg::TOUT_AFS]          = afs_q;
        pol.raw[timing_polarity_pkg::TOUT_TEN_FIELD]    = tfid_q;
        pol.raw[timing_polarity_pkg::TOUT_DE]           = de_q;
        pol.raw[timing_polarity_pkg::TOUT_FIELD]        = field_q;

        pol.invert[timing_polarity_pkg::TOUT_AFS]       = polarity_q[`BIT_POL_AFS];
        pol.invert[timing_polarity_pkg::TOUT_TEN_FIELD] = polarity_q[`BIT_POL_TEN_FIELD];
        pol.invert[timing_polarity_pkg::TOUT_DE]        = polarity_q[`BIT_POL_DE];
        pol.invert[timing_polarity_pkg::TOUT_FIELD]     = polarity_q[`BIT_POL_FIELD];

        // Without audio the frame sync stays low.
        pol.present[timing_polarity_pkg::TOUT_AFS]      = AUDIO_PRESENT;
    end

    polarity_stage #(
        .N (NOUT)
    ) u_pol (
        .pclk    (pclk),
        .presetn (presetn),
        .pol     (pol.stage)
    );

    // Bits follow the output enumeration.
    assign audio_frame_sync     = pol.out[timing_polarity_pkg::TOUT_AFS];
    assign ten_field_identifier = pol.out[timing_polarity_pkg::TOUT_TEN_FIELD];
    assign display_enable       = pol.out[timing_polarity_pkg::TOUT_DE];
    assign digital_field        = pol.out[timing_polarity_pkg::TOUT_FIELD];
endmodule
`default_nettype wire

/* File: testbench/tps_sva.sv */
// Port-level checks of the standard select and timing polarity block.
`include "timing_polarity_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tps_sva #(
    parameter bit AUDIO_PRESENT = 1'h1  // Audio variant.
) (
    input wire logic                       pclk,                 // Clock.
    input wire logic                       presetn,              // Reset.
    input wire logic                       psel,                 // Select.
    input wire logic                       penable,              // Access.
    input wire logic                       pwrite,               // Write.
    input wire logic [`APB_ADDR_WIDTH-1:0] paddr,                // Address.
    input wire logic [31:0]                pwdata,               // Write data.
    input wire logic [3:0]                 pstrb,                // Strobes.
    input wire logic [31:0]                prdata,               // Read data.
    input wire logic                       pready,               // Ready.
    input wire logic                       pslverr,              // Error.
    input wire logic [5:0]                 video_standard_pins,  // Pins.
    input wire logic                       line_start,           // Line pulse.
    input wire logic                       aclk_div_reset,       // Divider pulse.
    input wire logic                       ten_field_start,      // Sequence pulse.
    input wire logic                       active_pixel,         // Active level.
    input wire logic                       field_one,            // Field level.
    input wire logic [5:0]                 video_standard,       // Standard.
    input wire logic                       audio_frame_sync,     // Frame sync.
    input wire logic                       ten_field_identifier, // Ten-field.
    input wire logic                       display_enable,       // Enable.
    input wire logic                       digital_field         // Field flag.
);
    logic       wr;
    logic       mapped;
    logic       sel_q, sel_d;
    logic [5:0] std_q, std_d;
    logic [3:0] pol_q, pol_d;
    logic [1:0] up_q, up_d;
    assign wr = psel && penable && pwrite && pready;
    assign mapped = paddr == `ADDR_STD_SOURCE_CTRL || paddr == `ADDR_HOST_VIDEO_STD ||
                    paddr == `ADDR_TIMING_POLARITY || paddr == `ADDR_STANDARD_STATUS;
    // Shadow copies of the stored fields, updated at the write edge.
    always_comb begin
        sel_d = sel_q;
        std_d = std_q;
        pol_d = pol_q;
        up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
        if (wr && pstrb[0] && paddr == `ADDR_STD_SOURCE_CTRL) sel_d = pwdata[1];
        if (wr && pstrb[0] && paddr == `ADDR_HOST_VIDEO_STD) std_d = pwdata[5:0];
        if (wr && pstrb[1] && paddr == `ADDR_TIMING_POLARITY) pol_d[3:2] = pwdata[9:8];
        if (wr && pstrb[0] && paddr == `ADDR_TIMING_POLARITY) pol_d[1:0] = {pwdata[7], pwdata[5]};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= 1'h0;
            std_q <= 6'h00;
            pol_q <= 4'h0;
            up_q  <= 2'h0;
        end else begin
            sel_q <= sel_d;
            std_q <= std_d;
            pol_q <= pol_d;
            up_q  <= up_d;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY: assert property (pready == 1'h1) else $error("ready low");
    AST_ERR: assert property (psel && penable |-> pslverr == !mapped) else $error("bad error flag");
    AST_POL_READ: assert property (psel && penable && !pwrite &&
        paddr == `ADDR_TIMING_POLARITY |-> prdata == {22'h0, pol_q[3:1], 1'h0, pol_q[0], 5'h00})
        else $error("polarity readback");
    AST_CTRL_READ: assert property (psel && penable && !pwrite &&
        paddr == `ADDR_STD_SOURCE_CTRL |-> prdata == {30'h0, sel_q, 1'h0})
        else $error("control readback");
    AST_STD_HOST: assert property (up_q == 2'h3 && $past(sel_q) |->
        video_standard == $past(std_q)) else $error("host standard not used");
    AST_STD_PINS: assert property (up_q == 2'h3 && !$past(sel_q) |->
        video_standard == $past(video_standard_pins, 3)) else $error("pin standard not used");
    AST_DISP_EN: assert property (up_q == 2'h3 |-> display_enable ==
        ($past(active_pixel, 2) ^ $past(pol_q[1]))) else $error("display enable wrong");
    AST_FIELD_FLAG: assert property (up_q == 2'h3 |-> digital_field ==
        ($past(field_one, 2) ^ $past(pol_q[0]))) else $error("field flag wrong");
    AST_FRAME_SYNC: assert property (up_q == 2'h3 &&
        ($past(aclk_div_reset, 2) || $past(line_start, 2)) |-> audio_frame_sync ==
        (AUDIO_PRESENT && ($past(aclk_div_reset, 2) ^ $past(pol_q[3]))))
        else $error("frame sync wrong");
    AST_TEN_FIELD: assert property (up_q == 2'h3 &&
        ($past(ten_field_start, 2) || $past(line_start, 2)) |-> ten_field_identifier ==
        ($past(ten_field_start, 2) ^ $past(pol_q[2]))) else $error("ten-field wrong");
    COV_HOST: cover property (sel_q && up_q == 2'h3);
    COV_ERR: cover property (psel && penable && pslverr);
    COV_SYNC: cover property ($past(aclk_div_reset, 2) && pol_q[3]);
endmodule
bind timing_polarity_std_select tps_sva #(.AUDIO_PRESENT(AUDIO_PRESENT)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .video_standard_pins(video_standard_pins), .line_start(line_start),
    .aclk_div_reset(aclk_div_reset), .ten_field_start(ten_field_start),
    .active_pixel(active_pixel), .field_one(field_one), .video_standard(video_standard),
    .audio_frame_sync(audio_frame_sync), .ten_field_identifier(ten_field_identifier),
    .display_enable(display_enable), .digital_field(digital_field));
`default_nettype wire

/* File: testbench/apb_host.sv */
// Host processor model issuing APB transfers.
`include "timing_polarity_map.svh"
`timescale 1ns/100ps
`default_nettype none
module apb_host (
    input  wire logic        pclk,    // Clock.
    input  wire logic [31:0] prdata,  // Read data.
    input  wire logic        pready,  // Ready.
    input  wire logic        pslverr, // Error.
    output var  logic        psel,    // Select.
    output var  logic        penable, // Access.
    output var  logic        pwrite,  // Write.
    output var  logic [11:0] paddr,   // Address.
    output var  logic [31:0] pwdata,  // Write data.
    output var  logic [3:0]  pstrb    // Strobes.
);
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    // Called just after a rising edge; leaves the bus selected for back-to-back use.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        logic [31:0] m;
        m = 32'hFFFFFFFF;
        if (a == `ADDR_STD_SOURCE_CTRL) m = {16'h0, `MASK_STD_SOURCE_CTRL};
        if (a == `ADDR_HOST_VIDEO_STD) m = {16'h0, `MASK_HOST_VIDEO_STD};
        if (a == `ADDR_TIMING_POLARITY) m = {16'h0, `MASK_TIMING_POLARITY};
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d & m;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
    endtask
    task automatic idle;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

/* File: testbench/tb_timing_polarity_std_select.sv */
// Testbench of the standard select and timing polarity block.
`include "timing_polarity_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_timing_polarity_std_select;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [5:0]  pins, vstd;
    logic        ls, adr, tfs, ap, f1, fs, tfi, den, df, fs_na;
    int          n_mismatch, comparisons;
    apb_host u_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb));
    timing_polarity_std_select u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .video_standard_pins(pins),
        .line_start(ls), .aclk_div_reset(adr), .ten_field_start(tfs), .active_pixel(ap),
        .field_one(f1), .video_standard(vstd), .audio_frame_sync(fs),
        .ten_field_identifier(tfi), .display_enable(den), .digital_field(df));
    timing_polarity_std_select #(.AUDIO_PRESENT(1'h0)) u_dut_na (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(), .pready(), .pslverr(), .video_standard_pins(pins),
        .line_start(ls), .aclk_div_reset(adr), .ten_field_start(tfs), .active_pixel(ap),
        .field_one(f1), .video_standard(), .audio_frame_sync(fs_na),
        .ten_field_identifier(), .display_enable(), .digital_field());
    initial begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(1'h1, a, d, rd, err);
        chkb(err, 1'h0);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
        u_host.xfer(1'h0, a, 32'h0, rd, err);
        chk(rd, exp);
        chkb(err, eerr);
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic timing_test;
        logic v;
        for (int i = 0; i < 2; i++) begin
            v = i[0];
            wr(`ADDR_TIMING_POLARITY, v ? 32'h03A0 : 32'h0);
            u_host.idle;
            ap <= 1'h1;
            f1 <= 1'h0;
            adr <= 1'h1;
            tfs <= 1'h1;
            @(posedge pclk);
            adr <= 1'h0;
            tfs <= 1'h0;
            repeat (2) @(posedge pclk);
            #1;
            chkb(fs, ~v);
            chkb(tfi, ~v);
            chkb(den, ~v);
            chkb(df, v);
            chkb(fs_na, 1'h0);
            @(posedge pclk);
            ls <= 1'h1;
            ap <= 1'h0;
            f1 <= 1'h1;
            @(posedge pclk);
            ls <= 1'h0;
            repeat (2) @(posedge pclk);
            #1;
            chkb(fs, v);
            chkb(tfi, v);
            chkb(den, v);
            chkb(df, ~v);
            chkb(fs_na, 1'h0);
            @(posedge pclk);
        end
    endtask
    initial begin
        presetn = 1'h0;
        pins = 6'h00;
        {ls, adr, tfs, ap, f1} = 5'h00;
        n_mismatch = 0;
        comparisons = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rdc(`ADDR_STD_SOURCE_CTRL, 32'h0, 1'h0);
        rdc(`ADDR_HOST_VIDEO_STD, 32'h0, 1'h0);
        rdc(`ADDR_TIMING_POLARITY, 32'h0, 1'h0);
        $display("test reset done");
        wr(`ADDR_HOST_VIDEO_STD, 32'h0000002A);
        wr(`ADDR_TIMING_POLARITY, 32'h000003A0);
        rdc(`ADDR_TIMING_POLARITY, 32'h000003A0, 1'h0);
        rdc(`ADDR_HOST_VIDEO_STD, 32'h0000002A, 1'h0);
        rdc(12'h200, 32'h0, 1'h1);
        u_host.idle;
        $display("test registers done");
        pins <= 6'h15;
        repeat (4) @(posedge pclk);
        #1;
        chk({26'h0, vstd}, 32'h15);
        @(posedge pclk);
        wr(`ADDR_STD_SOURCE_CTRL, 32'h00000002);
        u_host.idle;
        pins <= 6'h3C;
        repeat (4) @(posedge pclk);
        #1;
        chk({26'h0, vstd}, 32'h2A);
        @(posedge pclk);
        rdc(`ADDR_STANDARD_STATUS, 32'h0000BC2A, 1'h0);
        wr(`ADDR_STD_SOURCE_CTRL, 32'h0);
        u_host.idle;
        repeat (2) @(posedge pclk);
        #1;
        chk({26'h0, vstd}, 32'h3C);
        @(posedge pclk);
        $display("test standard done");
        timing_test;
        $display("test timing done");
        summarize;
    end
    initial begin
        #800000;
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize;
    end
endmodule
`default_nettype wire
